// ---- core/ompl_addr_res.sv ----
`timescale 1ns/1ns
// turns the 8-bit register field into a 12-bit data address
module ompl_addr_res
    import ompl_pkg::*;
(
    input  wire logic [7:0]  f,        // register address field
    input  wire logic        use_bank, // 1: bank selector addressing
    input  wire logic        ext_en,   // extended set enabled
    input  wire logic [3:0]  bank_sel, // bank selector register
    input  wire logic [11:0] idx_base, // index pointer value
    output logic      [11:0] addr      // resolved address
);
    // whole field used, so 0..255 reach every byte of a bank
    always_comb begin
        if (use_bank) begin
            addr = {bank_sel, f};
        end else if (ext_en && f <= OMPL_IDX_MAX) begin
            // index wraps inside the 4 KiB space
            addr = 12'(idx_base + {4'h0, f});
        end else if (f <= OMPL_IDX_MAX) begin
            addr = {OMPL_ACC_LO, f};
        end else begin
            addr = {OMPL_ACC_HI, f};
        end
    end
endmodule

// ---- core/ompl_exec.sv ----
`timescale 1ns/1ns
//
// How it works
// - OR literal into accumulator, set N Z
// - OR accumulator with register, d picks destination
// - a=0 access bank, a=1 selected bank
// - extended set, a=0, f<=95: indexed offset
// - two-word pointer load forms 12-bit literal
// - high nibble first Q4, low byte second Q4
// - move register to accumulator or itself, N Z
// - field reaches all 256 bank bytes
module ompl_exec
    import ompl_pkg::*;
(
    input  wire logic                  clk_sys,    // 10 MHz core clock
    input  wire logic                  srst,       // sync reset, high
    input  wire logic [15:0]           instr_word, // word sampled in Q1
    input  wire logic                  ext_en,     // extended set enabled
    input  wire logic [3:0]            bank_sel,   // bank selector register
    input  wire logic [7:0]            mem_rdata,  // data memory read data
    output logic                       instr_take, // word taken this cycle
    output logic [OMPL_AW-1:0]         mem_addr,   // data memory address
    output logic [7:0]                 mem_wdata,  // data memory write data
    output logic                       mem_we,     // write strobe, Q4
    output logic [7:0]                 acc,        // working accumulator
    output logic                       flag_n,     // negative flag
    output logic                       flag_z,     // zero flag
    output logic [OMPL_NPTR-1:0][11:0] ptr         // indirect pointers
);
    ompl_phase_t               ph_q,     ph_d;     // quarter-cycle phase
    ompl_dec_t                 dec_q,    dec_d;    // decoded instruction
    ompl_dec_t                 dec_now;            // decode of instr_word
    logic                      second_q, second_d; // low word expected
    logic                      lo_q,     lo_d;     // executing low word
    logic [OMPL_AW-1:0]        addr_q,   addr_d;   // operand address
    logic [OMPL_AW-1:0]        res_addr;           // resolver output
    logic [7:0]                opnd_q,   opnd_d;   // fetched operand
    logic [7:0]                res_q,    res_d;    // processed result
    logic [7:0]                w_q,      w_d;      // accumulator
    logic                      n_q,      n_d;      // negative flag
    logic                      z_q,      z_d;      // zero flag
    logic                      we_q,     we_d;     // write strobe
    logic [7:0]                wdat_q,   wdat_d;   // write data
    logic [OMPL_NPTR-1:0][11:0] ptr_q,   ptr_d;    // pointers

    // field split of the incoming word
    always_comb begin
        dec_now.op        = ompl_classify(instr_word);
        dec_now.dest_file = instr_word[OMPL_D_BIT];
        dec_now.use_bank  = instr_word[OMPL_A_BIT];
        dec_now.f         = instr_word[7:0];
        dec_now.sel       = instr_word[5:4];
        dec_now.lit       = instr_word[7:0];
    end

    // address resolved straight from the word so it is ready in Q2
    ompl_addr_res u_res (
        .f        (dec_now.f),
        .use_bank (dec_now.use_bank),
        .ext_en   (ext_en),
        .bank_sel (bank_sel),
        .idx_base (ptr_q[OMPL_IDX_PTR]),
        .addr     (res_addr)
    );

    // next-state logic for the whole execution pipeline
    always_comb begin
        ph_d     = ph_q;
        dec_d    = dec_q;
        second_d = second_q;
        lo_d     = lo_q;
        addr_d   = addr_q;
        opnd_d   = opnd_q;
        res_d    = res_q;
        w_d      = w_q;
        n_d      = n_q;
        z_d      = z_q;
        we_d     = we_q;
        wdat_d   = wdat_q;
        ptr_d    = ptr_q;
        case (ph_q)
            OMPL_Q1: begin
                ph_d = OMPL_Q2;
                if (second_q) begin
                    // second word: only a proper tail completes the load
                    dec_d.lit = instr_word[7:0];
                    dec_d.op  = (instr_word[15:8] == OMPL_OP_LDPTR2) ?
                                OMPL_LDPTR : OMPL_NOP;
                    second_d  = 1'b0;
                    lo_d      = 1'b1;
                end else begin
                    dec_d  = dec_now;
                    lo_d   = 1'b0;
                    addr_d = res_addr;
                end
            end
            OMPL_Q2: begin
                ph_d = OMPL_Q3;
                // literal ops never touch memory
                if (dec_q.op == OMPL_ORLIT) begin
                    opnd_d = dec_q.lit;
                end else begin
                    opnd_d = mem_rdata;
                end
            end
            OMPL_Q3: begin
                ph_d = OMPL_Q4;
                if (dec_q.op == OMPL_MOVE_FILE_REGISTER) begin
                    res_d = opnd_q;
                end else begin
                    res_d = w_q | opnd_q;
                end
                // register destination is strobed for the whole of Q4
                we_d   = (dec_q.op == OMPL_ORFILE || dec_q.op == OMPL_MOVE_FILE_REGISTER)
                         && dec_q.dest_file;
                wdat_d = (dec_q.op == OMPL_MOVE_FILE_REGISTER) ? opnd_q : (w_q | opnd_q);
            end
            OMPL_Q4: begin
                ph_d = OMPL_Q1;
                we_d = 1'b0;
                case (dec_q.op)
                    OMPL_ORLIT, OMPL_ORFILE, OMPL_MOVE_FILE_REGISTER: begin
                        n_d = res_q[7];
                        z_d = (res_q == 8'h00);
                        if (dec_q.op == OMPL_ORLIT || !dec_q.dest_file) begin
                            w_d = res_q;
                        end
                    end
                    OMPL_LDPTR: begin
                        // flags are left alone by the pointer load
                        if (lo_q) begin
                            ptr_d[dec_q.sel][7:0] = dec_q.lit;
                        end else begin
                            ptr_d[dec_q.sel][11:8] = dec_q.lit[3:0];
                            second_d = 1'b1;
                        end
                    end
                    default: begin
                        w_d = w_q;
                    end
                endcase
            end
            default: begin
                ph_d = OMPL_Q1;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ph_q     <= OMPL_Q1;
            dec_q    <= '0;
            second_q <= 1'b0;
            lo_q     <= 1'b0;
            addr_q   <= OMPL_ADDR_RST;
            opnd_q   <= 8'h00;
            res_q    <= 8'h00;
            w_q      <= OMPL_W_RST;
            n_q      <= 1'b0;
            z_q      <= 1'b0;
            we_q     <= 1'b0;
            wdat_q   <= 8'h00;
            ptr_q    <= {OMPL_NPTR{OMPL_PTR_RST}};
        end else begin
            ph_q     <= ph_d;
            dec_q    <= dec_d;
            second_q <= second_d;
            lo_q     <= lo_d;
            addr_q   <= addr_d;
            opnd_q   <= opnd_d;
            res_q    <= res_d;
            w_q      <= w_d;
            n_q      <= n_d;
            z_q      <= z_d;
            we_q     <= we_d;
            wdat_q   <= wdat_d;
            ptr_q    <= ptr_d;
        end
    end

    // outputs straight from flops, take is the Q1 phase decode held low during srst
    assign instr_take = (ph_q == OMPL_Q1) && !srst;
    assign mem_addr   = addr_q;
    assign mem_wdata  = wdat_q;
    assign mem_we     = we_q;
    assign acc        = w_q;
    assign flag_n     = n_q;
    assign flag_z     = z_q;
    assign ptr        = ptr_q;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    logic first_q1; // fresh one-word decode in this Q1
    assign first_q1 = (ph_q == OMPL_Q1) && !second_q;

    a_phase_order: assert property (
        ph_q == OMPL_Q1 |=> ph_q == OMPL_Q2 ##1 ph_q == OMPL_Q3
                            ##1 ph_q == OMPL_Q4 ##1 ph_q == OMPL_Q1)
        else $error("phase order broken");
    a_orlit_result: assert property (
        first_q1 && ompl_classify(instr_word) == OMPL_ORLIT |->
        ##4 w_q == ($past(w_q, 4) | $past(instr_word[7:0], 4))
            && z_q == (w_q == 8'h00) && n_q == w_q[7])
        else $error("literal OR result wrong");
    a_orfile_write: assert property (
        ph_q == OMPL_Q3 && dec_q.op == OMPL_ORFILE && dec_q.dest_file |=>
        mem_we && mem_wdata == (w_q | opnd_q) ##1 !mem_we)
        else $error("register OR write wrong");
    a_bank_addr: assert property (
        first_q1 && ompl_classify(instr_word) == OMPL_MOVE_FILE_REGISTER
        && instr_word[OMPL_A_BIT] |=>
        mem_addr == {$past(bank_sel), $past(instr_word[7:0])})
        else $error("banked address wrong");
    a_access_addr: assert property (
        first_q1 && ompl_classify(instr_word) == OMPL_ORFILE
        && !instr_word[OMPL_A_BIT] && instr_word[7:0] > OMPL_IDX_MAX |=>
        mem_addr == {OMPL_ACC_HI, $past(instr_word[7:0])})
        else $error("access address wrong");
    a_indexed_addr: assert property (
        first_q1 && ext_en && !instr_word[OMPL_A_BIT]
        && instr_word[7:0] <= OMPL_IDX_MAX |=>
        mem_addr == 12'($past(ptr_q[OMPL_IDX_PTR])
                        + {4'h0, $past(instr_word[7:0])}))
        else $error("indexed address wrong");
    a_ptr_high: assert property (
        ph_q == OMPL_Q4 && dec_q.op == OMPL_LDPTR && !lo_q |=>
        ptr_q[$past(dec_q.sel)][11:8] == $past(dec_q.lit[3:0]) && second_q)
        else $error("pointer high byte wrong");
    a_ptr_low: assert property (
        ph_q == OMPL_Q4 && dec_q.op == OMPL_LDPTR && lo_q |=>
        ptr_q[$past(dec_q.sel)][7:0] == $past(dec_q.lit)
        && $stable(n_q) && $stable(z_q))
        else $error("pointer low byte or flags wrong");
    a_move_file_register_flags: assert property (
        ph_q == OMPL_Q4 && dec_q.op == OMPL_MOVE_FILE_REGISTER |=>
        z_q == ($past(res_q) == 8'h00) && n_q == $past(res_q[7]))
        else $error("move flags wrong");
    a_we_in_q4: assert property (
        mem_we |-> ph_q == OMPL_Q4)
        else $error("write outside Q4");

    c_orlit: cover property (ph_q == OMPL_Q4 && dec_q.op == OMPL_ORLIT);
    c_move_file_register_file: cover property (mem_we && dec_q.op == OMPL_MOVE_FILE_REGISTER);
    c_ptr_low: cover property (ph_q == OMPL_Q4 && dec_q.op == OMPL_LDPTR
                               && lo_q);
    c_indexed: cover property (first_q1 && ext_en
                               && !instr_word[OMPL_A_BIT]);
endmodule

// ---- core/ompl_pkg.sv ----
package ompl_pkg;
    // data space and field layout
    localparam int          OMPL_AW        = 12;     // data address width
    localparam int          OMPL_NPTR      = 3;      // number of pointers
    localparam int          OMPL_IDX_PTR   = 2;      // pointer used as index
    localparam int          OMPL_D_BIT     = 9;      // destination bit
    localparam int          OMPL_A_BIT     = 8;      // bank-select bit
    // opcode prefixes
    localparam logic [7:0]  OMPL_OP_ORLIT  = 8'h09;  // 0000 1001
    localparam logic [5:0]  OMPL_OP_ORFILE = 6'h04;  // 0001 00
    localparam logic [5:0]  OMPL_OP_MOVE_FILE_REGISTER   = 6'h14;  // 0101 00
    localparam logic [9:0]  OMPL_OP_LDPTR1 = 10'h3b8; // 1110 1110 00
    localparam logic [7:0]  OMPL_OP_LDPTR2 = 8'hf0;  // 1111 0000
    // addressing
    localparam logic [7:0]  OMPL_IDX_MAX   = 8'h5f;  // top of low access part
    localparam logic [3:0]  OMPL_ACC_LO    = 4'h0;   // bank of low access part
    localparam logic [3:0]  OMPL_ACC_HI    = 4'hf;   // bank of high access part
    localparam logic [1:0]  OMPL_SEL_BAD   = 2'h3;   // no such pointer
    // reset values
    localparam logic [7:0]  OMPL_W_RST     = 8'h00;  // accumulator
    localparam logic [11:0] OMPL_PTR_RST   = 12'h000; // pointers
    localparam logic [11:0] OMPL_ADDR_RST  = 12'h000; // memory address

    typedef enum logic [2:0] {
        OMPL_NOP, OMPL_ORLIT, OMPL_ORFILE, OMPL_MOVE_FILE_REGISTER, OMPL_LDPTR
    } ompl_op_t;

    typedef enum logic [1:0] {
        OMPL_Q1, OMPL_Q2, OMPL_Q3, OMPL_Q4
    } ompl_phase_t;

    typedef struct packed {
        ompl_op_t   op;        // operation
        logic       dest_file; // result back to the register
        logic       use_bank;  // bank selector addressing
        logic [7:0] f;         // register address field
        logic [1:0] sel;       // pointer select
        logic [7:0] lit;       // literal bits
    } ompl_dec_t;

    // opcode classification, shared by datapath and checks
    function automatic ompl_op_t ompl_classify(input logic [15:0] w);
        ompl_op_t op;
        op = OMPL_NOP;
        if (w[15:8] == OMPL_OP_ORLIT) begin
            op = OMPL_ORLIT;
        end else if (w[15:10] == OMPL_OP_ORFILE) begin
            op = OMPL_ORFILE;
        end else if (w[15:10] == OMPL_OP_MOVE_FILE_REGISTER) begin
            op = OMPL_MOVE_FILE_REGISTER;
        end else if (w[15:6] == OMPL_OP_LDPTR1 && w[5:4] != OMPL_SEL_BAD) begin
            op = OMPL_LDPTR;
        end
        return op;
    endfunction
endpackage

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
module tb_top
    import ompl_pkg::*;
;
    logic                       clk_sys    = 1'b0;   // core clock
    logic                       srst       = 1'b1;   // sync reset
    logic [15:0]                instr_word = 16'h0;  // word to execute
    logic                       ext_en     = 1'b0;   // extended set
    logic [3:0]                 bank_sel   = 4'h0;   // bank selector
    logic [7:0]                 mem_rdata;           // memory read data
    logic                       instr_take;          // q1 marker
    logic [OMPL_AW-1:0]         mem_addr;            // operand address
    logic [7:0]                 mem_wdata;           // write data
    logic                       mem_we;              // write strobe
    logic [7:0]                 acc;                 // accumulator
    logic                       flag_n;              // negative flag
    logic                       flag_z;              // zero flag
    logic [OMPL_NPTR-1:0][11:0] ptr;                 // pointers
    logic [7:0]                 mem [0:4095];        // data memory
    logic [7:0]                 m_acc;               // model accumulator
    logic                       m_n;                 // model negative
    logic                       m_z;                 // model zero
    logic [11:0]                m_ptr [0:2];         // model pointers
    logic                       m_pend;              // pointer load open
    logic [1:0]                 m_sel;               // pending pointer
    logic [31:0]                rnd;                 // load_pointer_literal state
    int                         err_total = 0;       // mismatches
    int                         samples_checked = 0; // comparisons

    ompl_exec dut (
        .clk_sys(clk_sys), .srst(srst), .instr_word(instr_word),
        .ext_en(ext_en), .bank_sel(bank_sel), .mem_rdata(mem_rdata),
        .instr_take(instr_take), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .acc(acc),
        .flag_n(flag_n), .flag_z(flag_z), .ptr(ptr)
    );

    // memory answers at once, as the core expects during q2
    assign mem_rdata = mem[mem_addr];

    // memory takes the q4 write at the closing edge
    always @(posedge clk_sys) begin
        if (mem_we === 1'b1) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    // free running clock, 100 ns period
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // taps give a long sequence; seed fixed for repeatable runs
    function automatic logic [31:0] load_pointer_literal(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d, checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // reset for n edges, look at the outputs, release on the next edge
    task automatic do_reset(input int n);
        srst <= 1'b1;
        instr_word <= 16'h0;
        repeat (n) @(posedge clk_sys);
        #1;
        chk(12'(acc), 12'h0, "acc in reset");
        chk(12'({instr_take, mem_we, flag_n, flag_z}), 12'h0, "reset bits");
        for (int i = 0; i < 3; i++) chk(ptr[i], 12'h0, "ptr in reset");
        @(posedge clk_sys);
        srst <= 1'b0;
        m_acc = 8'h0;
        {m_n, m_z, m_pend, m_sel} = 5'h0;
        for (int i = 0; i < 3; i++) m_ptr[i] = 12'h0;
    endtask

    // one instruction cycle; first compares the result of the previous one
    task automatic do_word(input logic [15:0] w, input logic e,
                           input logic [3:0] b);
        logic [11:0] ea;
        logic [7:0]  res;
        logic        xw;
        logic        isf;
        instr_word <= w;
        ext_en <= e;
        bank_sel <= b;
        #1;
        chk(12'(instr_take), 12'h1, "take in q1");
        chk(12'(mem_we), 12'h0, "no write in q1");
        chk(12'(acc), 12'(m_acc), "acc");
        chk(12'({flag_n, flag_z}), 12'({m_n, m_z}), "flags");
        for (int i = 0; i < 3; i++) chk(ptr[i], m_ptr[i], "ptr");
        xw = 1'b0;
        ea = 12'h0;
        res = 8'h0;
        isf = (w[15:10] == OMPL_OP_ORFILE) || (w[15:10] == OMPL_OP_MOVE_FILE_REGISTER);
        // a word after a first pointer word is always its second word
        if (m_pend) begin
            if (w[15:8] == OMPL_OP_LDPTR2) m_ptr[m_sel][7:0] = w[7:0];
            m_pend = 1'b0;
            isf = 1'b0;
        end else if (w[15:8] == OMPL_OP_ORLIT) begin
            m_acc = m_acc | w[7:0];
            m_n = m_acc[7];
            m_z = (m_acc == 8'h0);
        end else if (isf) begin
            // a=1 bank selector, else access bank or indexed offset
            if (w[8]) ea = {b, w[7:0]};
            else if (w[7:0] > OMPL_IDX_MAX) ea = {4'hf, w[7:0]};
            else if (e) ea = m_ptr[2] + {4'h0, w[7:0]};
            else ea = {4'h0, w[7:0]};
            res = mem[ea];
            if (w[15:10] == OMPL_OP_ORFILE) res = res | m_acc;
            if (w[9]) xw = 1'b1;
            else m_acc = res;
            m_n = res[7];
            m_z = (res == 8'h0);
        end else if (w[15:6] == OMPL_OP_LDPTR1 && w[5:4] != 2'h3) begin
            m_ptr[w[5:4]][11:8] = w[3:0];
            m_sel = w[5:4];
            m_pend = 1'b1;
        end
        repeat (3) @(posedge clk_sys);
        #1;
        chk(12'(mem_we), 12'(xw), "write strobe q4");
        if (isf) chk(mem_addr, ea, "operand address");
        if (xw) chk(12'(mem_wdata), 12'(res), "write data");
        @(posedge clk_sys);
    endtask

    // watchdog: the whole run needs well under 1 ms
    initial begin
        #1_000_000;
        err_total++;
        tally_and_finish;
    end

    initial begin
        logic [7:0] fv [4];
        fv = '{8'h00, 8'h5f, 8'h60, 8'hff};
        rnd = 32'h8bc487c2;
        for (int i = 0; i < 4096; i++) begin
            rnd = load_pointer_literal(rnd);
            mem[i] = rnd[7:0];
        end
        do_reset(4);
        do_word(16'h0900, 1'b0, 4'h0);
        do_word(16'h099a, 1'b0, 4'h0);
        do_word(16'h0935, 1'b0, 4'h0);
        // every pointer, then a refused select and a broken second word
        for (int s = 0; s < 4; s++) begin
            do_word({OMPL_OP_LDPTR1, 2'(s), 4'h3}, 1'b0, 4'h0);
            do_word({OMPL_OP_LDPTR2, 8'hab}, 1'b0, 4'h0);
        end
        do_word({OMPL_OP_LDPTR1, 2'h1, 4'hc}, 1'b0, 4'h0);
        do_word(16'hf155, 1'b0, 4'h0);
        // address field edges in every addressing mode
        for (int i = 0; i < 16; i++) begin
            do_word({OMPL_OP_MOVE_FILE_REGISTER, 1'b1, i[0], fv[i[3:2]]}, i[1], 4'h7);
            do_word({OMPL_OP_ORFILE, 1'b0, i[0], fv[i[3:2]]}, i[1], 4'h3);
        end
        do_word(16'h09ff, 1'b0, 4'h0);
        do_reset(2);
        // random traffic, back to back
        for (int k = 0; k < 300; k++) begin
            rnd = load_pointer_literal(rnd);
            case (rnd[1:0])
                2'd0: do_word({OMPL_OP_ORLIT, rnd[15:8]}, rnd[24], rnd[28:25]);
                2'd1: do_word({OMPL_OP_ORFILE, rnd[9:8], rnd[23:16]}, rnd[24], rnd[28:25]);
                2'd2: do_word({OMPL_OP_MOVE_FILE_REGISTER, rnd[9:8], rnd[23:16]}, rnd[24], rnd[28:25]);
                default: begin
                    do_word({OMPL_OP_LDPTR1, rnd[5:4], rnd[11:8]}, rnd[24], rnd[28:25]);
                    do_word({rnd[30] ? 8'hf1 : OMPL_OP_LDPTR2, rnd[23:16]}, rnd[24], rnd[28:25]);
                end
            endcase
        end
        do_word(16'h0000, 1'b0, 4'h0);
        tally_and_finish;
    end
endmodule
